// ---- bench/tpoc_printer_model.sv ----
// Purpose: parallel printer at the far side
// Assumes: one character per strobe
// Notes: demand drops as each strobe starts, so pacing is exercised
`timescale 1ns/1ps
module tpoc_printer_model (
  input wire logic i_clk,
  input wire logic [7:0] i_data,
  input wire logic i_strobe,
  output logic o_demand
);
  logic [7:0] q[$];
  logic stb_reg;
  int busy;
  initial begin
    o_demand = 1;
    stb_reg = 0;
    busy = 0;
  end
  always @(posedge i_clk) begin
    stb_reg <= i_strobe;
    if (i_strobe && !stb_reg) q.push_back(i_data);
    if (i_strobe && !stb_reg) begin
      o_demand <= 0;
      busy <= 200;
    end else if (busy > 0) begin
      busy <= busy - 1;
      o_demand <= (busy == 1);
    end
  end
endmodule : tpoc_printer_model

// ---- bench/tpoc_top_asserts.sv ----
// Purpose: port checker of the print output controller
// Assumes: bound to tpoc_top, one clock domain
// Notes: strobe width is counted in helper logic
`timescale 1ns/1ps
module tpoc_top_asserts (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_s_axi_awvalid,
  input wire logic o_s_axi_awready,
  input wire logic i_s_axi_wvalid,
  input wire logic o_s_axi_wready,
  input wire logic o_s_axi_bvalid,
  input wire logic i_s_axi_arvalid,
  input wire logic o_s_axi_arready,
  input wire logic o_s_axi_rvalid,
  input wire logic i_host_valid,
  input wire logic o_host_ready,
  input wire logic o_flow_valid,
  input wire logic [7:0] o_flow_char,
  input wire logic i_flow_ready,
  input wire logic [7:0] o_par_data,
  input wire logic o_par_strobe
);
  logic [7:0] cnt_reg;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) cnt_reg <= 8'h00;
    else cnt_reg <= o_par_strobe ? cnt_reg + 8'h01 : 8'h00;
  end
  sequence s_wtake;
    i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready;
  endsequence
  property p_wresp; s_wtake |-> ##2 o_s_axi_bvalid; endproperty
  a_wresp: assert property (p_wresp) else $error("write answer late");
  property p_bstay; o_s_axi_bvalid |-> !o_s_axi_awready; endproperty
  a_bstay: assert property (p_bstay) else $error("awready early");
  property p_rresp; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid;
  endproperty
  a_rresp: assert property (p_rresp) else $error("read answer late");
  property p_take; i_host_valid && o_host_ready |=> !o_host_ready;
  endproperty
  a_take: assert property (p_take) else $error("host ready stuck");
  property p_flow;
    o_flow_valid && !i_flow_ready |=> o_flow_valid && $stable(o_flow_char);
  endproperty
  a_flow: assert property (p_flow)
    else $error("flow char dropped");
  property p_fcode; o_flow_valid |-> o_flow_char inside {8'h13, 8'h11};
  endproperty
  a_fcode: assert property (p_fcode)
    else $error("flow code wrong");
  property p_pdata; o_par_strobe |-> $stable(o_par_data); endproperty
  a_pdata: assert property (p_pdata)
    else $error("data moved in strobe");
  property p_pwidth; $fell(o_par_strobe) |-> cnt_reg == 8'h7d; endproperty
  a_pwidth: assert property (p_pwidth)
    else $error("strobe width wrong");
endmodule : tpoc_top_asserts

bind tpoc_top tpoc_top_asserts tpoc_top_asserts_i (.*);

// ---- bench/tpoc_top_tb.sv ----
// Purpose: self-checking bench of the print output controller
// Assumes: parallel printer, screen blank except row 5
// Notes: row 5 holds A, blank 00, C, then trailing spaces
`timescale 1ns/1ps
module tpoc_top_tb;
  logic i_clk, i_reset_n, i_ce, i_s_axi_awvalid, i_s_axi_wvalid;
  logic i_s_axi_bready, i_s_axi_arvalid, i_s_axi_rready, i_host_valid;
  logic i_copy_key, i_shift, i_flow_ready, i_silo_empty, i_par_demand;
  logic o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
  logic o_s_axi_rvalid, o_host_ready, o_flow_valid, o_par_strobe;
  logic o_ser_txd, o_hold;
  logic [7:0] i_s_axi_awaddr, i_s_axi_araddr, i_host_char, i_scr_char;
  logic [7:0] o_flow_char, o_par_data;
  logic [31:0] i_s_axi_wdata, o_s_axi_rdata, d;
  logic [3:0] i_s_axi_wstrb;
  logic [1:0] o_s_axi_bresp, o_s_axi_rresp, r;
  logic [4:0] i_cursor_row, o_scr_row;
  logic [6:0] o_scr_col;
  logic [2:0] i_sel;
  logic [7:0] ex[$], fq[$];
  int fails, n_tests;
  tpoc_top #(.P_CLK_HZ(96000)) tpoc_top_i (.*);
  tpoc_printer_model tpoc_printer_model_i (.i_clk(i_clk),
    .i_data(o_par_data), .i_strobe(o_par_strobe), .o_demand(i_par_demand));
  initial begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    i_scr_char <= (o_scr_row != 5'h05 || o_scr_col > 7'h02) ? 8'h20 :
      (o_scr_col == 7'h01) ? 8'h00 : 8'h41 + 8'(o_scr_col);
    i_flow_ready <= ~i_flow_ready;
    if (o_flow_valid && i_flow_ready) fq.push_back(o_flow_char);
  end
  task end_sim;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task hs(input logic [7:0] c);
    i_host_valid <= 1;
    i_host_char <= c;
    @(posedge i_clk iff o_host_ready);
    i_host_valid <= 0;
    @(posedge i_clk);
  endtask : hs
  task cp(input logic s);
    i_shift <= s;
    i_copy_key <= 1;
    @(posedge i_clk);
    i_copy_key <= 0;
    repeat (20) @(posedge i_clk);
  endtask : cp
  task wr(input logic [7:0] a, input logic [31:0] dv);
    i_s_axi_awvalid <= 1;
    i_s_axi_awaddr <= a;
    i_s_axi_wvalid <= 1;
    i_s_axi_wdata <= dv;
    i_s_axi_wstrb <= 4'hf;
    i_s_axi_bready <= 1;
    fork
      begin
        @(posedge i_clk iff o_s_axi_awready);
        i_s_axi_awvalid <= 0;
      end
      begin
        @(posedge i_clk iff o_s_axi_wready);
        i_s_axi_wvalid <= 0;
      end
    join
    @(posedge i_clk iff o_s_axi_bvalid);
    i_s_axi_bready <= 0;
    @(posedge i_clk);
  endtask : wr
  task rd(input logic [7:0] a);
    i_s_axi_arvalid <= 1;
    i_s_axi_araddr <= a;
    i_s_axi_rready <= 1;
    @(posedge i_clk iff o_s_axi_arready);
    i_s_axi_arvalid <= 0;
    @(posedge i_clk iff o_s_axi_rvalid);
    d = o_s_axi_rdata;
    r = o_s_axi_rresp;
    i_s_axi_rready <= 0;
    @(posedge i_clk);
  endtask : rd
  task ln(input bit t);
    if (t) ex = {ex, 8'h41, 8'h20, 8'h43};
    ex = {ex, 8'h0d, 8'h0a};
  endtask : ln
  // Waits for the expected count, then lingers to catch extras
  task chk_out;
    int i;
    i = 0;
    while (tpoc_printer_model_i.q.size() < ex.size() && i < 20000) begin
      @(posedge i_clk);
      i++;
    end
    repeat (400) @(posedge i_clk);
    chk(tpoc_printer_model_i.q.size(), ex.size());
    foreach (ex[k]) chk(tpoc_printer_model_i.q[k], ex[k]);
    tpoc_printer_model_i.q.delete();
    ex.delete();
  endtask : chk_out
  task t_regs;
    rd(8'h00);
    chk(d, 32'h1);
    rd(8'h04);
    chk(d, 32'h80);
    rd(8'h40);
    chk({d, r}, 34'h3);
    wr(8'h00, 32'h0);
    rd(8'h00);
    chk(d, 32'h0);
    wr(8'h00, 32'h1);
  endtask : t_regs
  task t_line;
    fq.delete();
    hs(8'h1b);
    hs(8'h56);
    chk(o_hold, 1);
    ln(1);
    chk_out;
    chk({fq.size(), fq[0], fq[1]}, 32'h21311);
  endtask : t_line
  task t_pass;
    hs(8'h1b);
    hs(8'h57);
    hs(8'h1b);
    hs(8'h56);
    hs(8'h1b);
    hs(8'h58);
    ex = {8'h1b, 8'h56, 8'h1b, 8'h18};
    chk_out;
    rd(8'h04);
    chk(d[1], 0);
  endtask : t_pass
  task t_screen;
    for (int m = 0; m < 2; m++) begin
      if (m == 0) cp(0);
      else begin
        hs(8'h1b);
        hs(8'h5d);
      end
      for (int k = 0; k < 24; k++) ln(k == 5);
      chk_out;
    end
  endtask : t_screen
  task t_lf;
    cp(1);
    rd(8'h04);
    chk(d[0], 1);
    hs(8'h0a);
    ln(1);
    chk_out;
    cp(1);
    hs(8'h0a);
    chk_out;
    hs(8'h1b);
    hs(8'h5e);
    rd(8'h04);
    chk(d[0], 1);
    hs(8'h1b);
    hs(8'h5f);
    rd(8'h04);
    chk(d[0], 0);
    chk_out;
  endtask : t_lf
  task t_ser;
    i_sel <= 3'h7;
    hs(8'h1b);
    hs(8'h57);
    hs(8'h5a);
    repeat (5) @(posedge i_clk);
    for (int b = 0; b < 10; b++) begin
      chk(o_ser_txd, (10'h2b4 >> b) & 10'h1);
      repeat (10) @(posedge i_clk);
    end
  endtask : t_ser
  initial begin
    {i_reset_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = '0;
    {i_s_axi_arvalid, i_s_axi_rready, i_host_valid, i_copy_key} = '0;
    {i_shift, i_flow_ready, i_sel, i_host_char} = '0;
    {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata, i_s_axi_wstrb} = '0;
    {i_ce, i_silo_empty, i_cursor_row} = 7'h65;
    fails = 0;
    n_tests = 0;
    repeat (16) @(posedge i_clk);
    i_reset_n <= 1;
    repeat (40) @(posedge i_clk);
    t_regs;
    t_line;
    t_pass;
    t_screen;
    t_lf;
    t_ser;
    end_sim;
  end
  initial begin
    repeat (80000) @(posedge i_clk);
    fails++;
    end_sim;
  end
endmodule : tpoc_top_tb

// ---- include/tpoc_defines.svh ----
// Purpose: shared constants of the terminal print output controller
// Assumes: 125 MHz system clock, AXI4-Lite register access
// Notes: character codes are 8-bit ASCII
//
// What this block does
// - Selector position 1 is parallel; 2..8 are serial 150..9600 baud.
// - Printer rate is independent of host rate; printer must match it.
// - Copy key without shift prints the whole screen.
// - Copy key with shift toggles line-feed print mode.
// - In line-feed print mode each line feed outside pass-through prints the cursor line.
// - Copy key actions send nothing to the host; a copy-key screen print still sends XOFF, then XON.
// - ESC 135 prints screen, ESC 136 enters, ESC 137 leaves LF mode.
// - ESC 126 prints the whole cursor line.
// - After ESC 127 every received character goes unchanged to printer.
// - The ESC 127 pair itself is not forwarded.
// - ESC 130 ends pass-through; cancel 030 replaces the final character.
// - Print line outputs one line, print screen outputs 24 lines.
// - Entering or leaving LF mode prints nothing by itself.
// - A line is 80 codes left to right, then CR 015 and LF 012.
// - Blanks inside the text are sent as space 040.
// - With 16 or more trailing blanks, trim them and end the line.
// - Host is paused with XOFF until the line is printed, then XON.
// - Stall host characters into the silo; XON once the silo is empty.
`ifndef TPOC_DEFINES_SVH
`define TPOC_DEFINES_SVH

`define TPOC_ADDR_W 8
`define TPOC_CTRL_OFF 8'h00
`define TPOC_STATUS_OFF 8'h04
`define TPOC_CTRL_RESET 32'h0000_0001
`define TPOC_CTRL_EN_BIT 0

`define TPOC_CH_ESC 8'h1b
`define TPOC_CH_SCREEN 8'h5d
`define TPOC_CH_LF_ON 8'h5e
`define TPOC_CH_LF_OFF 8'h5f
`define TPOC_CH_LINE 8'h56
`define TPOC_CH_PT_ON 8'h57
`define TPOC_CH_PT_OFF 8'h58
`define TPOC_CH_CAN 8'h18
`define TPOC_CH_CR 8'h0d
`define TPOC_CH_LF 8'h0a
`define TPOC_CH_SPACE 8'h20
`define TPOC_CH_XOFF 8'h13
`define TPOC_CH_XON 8'h11

`define TPOC_COLS 80
`define TPOC_ROWS 24
`define TPOC_TRIM_MIN 16
`define TPOC_FIFO_DEPTH 4

`define TPOC_CLK_HZ 125000000
`define TPOC_STROBE_NS 1000
`define TPOC_STROBE_CYC \
  ((`TPOC_STROBE_NS * (`TPOC_CLK_HZ / 1000000) + 999) / 1000)
`define TPOC_SEL_PARALLEL 3'h0

`endif

// ---- include/tpoc_pkg.sv ----
// Purpose: types of the terminal print output controller
// Assumes: constants come from tpoc_defines.svh
// Notes: state codes are one-hot
package tpoc_pkg;

  typedef enum logic [5:0] {
    TPOC_F_IDLE = 6'h01,
    TPOC_F_SCAN = 6'h02,
    TPOC_F_SEND = 6'h04,
    TPOC_F_CR = 6'h08,
    TPOC_F_LF = 6'h10,
    TPOC_F_DONE = 6'h20
  } tpoc_fmt_state_t;

  typedef enum logic [4:0] {
    TPOC_O_IDLE = 5'h01,
    TPOC_O_PSET = 5'h02,
    TPOC_O_PSTB = 5'h04,
    TPOC_O_PHLD = 5'h08,
    TPOC_O_SER = 5'h10
  } tpoc_out_state_t;

  typedef struct packed {
    logic [23:0] zero;
    logic demand;
    logic [2:0] sel;
    logic xoff_sent;
    logic busy;
    logic passthru;
    logic lf_mode;
  } tpoc_status_t;

endpackage : tpoc_pkg

// ---- src/tpoc_fifo.sv ----
// Purpose: small FIFO between line formatter and printer port
// Assumes: one clock, clock enable freezes it
// Notes: depth must be a power of two
`timescale 1ns/1ps
module tpoc_fifo #(
  parameter int unsigned W = 8,
  parameter int unsigned D = 4
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_in_valid,
  input wire logic [W-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  output logic [W-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int unsigned AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0] wr_ptr_reg;
  logic [AW:0] rd_ptr_reg;
  wire full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
              (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  wire empty = wr_ptr_reg == rd_ptr_reg;
  wire push = i_in_valid && !full;
  wire pop = i_out_ready && !empty;

  assign o_in_ready = !full;
  assign o_out_valid = !empty;
  assign o_out_data = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge i_clk) begin
    if (i_ce && push) begin
      mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else if (i_ce) begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule : tpoc_fifo

// ---- src/tpoc_top.sv ----
// Purpose: print output control of a video terminal
// Assumes: screen read port answers one cycle after the address
// Notes: selector and demand pins are synchronised here
//
// Added by the designer: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "tpoc_defines.svh"
module tpoc_top #(
  parameter int unsigned P_CLK_HZ = `TPOC_CLK_HZ
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_ce,
  input wire logic i_s_axi_awvalid,
  output logic o_s_axi_awready,
  input wire logic [`TPOC_ADDR_W-1:0] i_s_axi_awaddr,
  input wire logic i_s_axi_wvalid,
  output logic o_s_axi_wready,
  input wire logic [31:0] i_s_axi_wdata,
  input wire logic [3:0] i_s_axi_wstrb,
  output logic o_s_axi_bvalid,
  input wire logic i_s_axi_bready,
  output logic [1:0] o_s_axi_bresp,
  input wire logic i_s_axi_arvalid,
  output logic o_s_axi_arready,
  input wire logic [`TPOC_ADDR_W-1:0] i_s_axi_araddr,
  output logic o_s_axi_rvalid,
  input wire logic i_s_axi_rready,
  output logic [31:0] o_s_axi_rdata,
  output logic [1:0] o_s_axi_rresp,
  input wire logic i_host_valid,
  input wire logic [7:0] i_host_char,
  output logic o_host_ready,
  input wire logic [4:0] i_cursor_row,
  input wire logic i_copy_key,
  input wire logic i_shift,
  output logic [4:0] o_scr_row,
  output logic [6:0] o_scr_col,
  input wire logic [7:0] i_scr_char,
  output logic o_flow_valid,
  output logic [7:0] o_flow_char,
  input wire logic i_flow_ready,
  input wire logic i_silo_empty,
  input wire logic [2:0] i_sel,
  input wire logic i_par_demand,
  output logic [7:0] o_par_data,
  output logic o_par_strobe,
  output logic o_ser_txd,
  output logic o_hold
);
  import tpoc_pkg::*;

  localparam logic [6:0] LAST_COL = 7'(`TPOC_COLS - 1);
  localparam logic [6:0] TRIM_LAST = 7'(`TPOC_COLS - 1 - `TPOC_TRIM_MIN);
  localparam logic [4:0] LAST_ROW = 5'(`TPOC_ROWS - 1);
  localparam logic [19:0] STB_CYC = 20'(`TPOC_STROBE_CYC);

  function automatic logic blank(input logic [7:0] c);
    blank = (c == `TPOC_CH_SPACE) || (c == 8'h00);
  endfunction : blank

  function automatic logic [19:0] bit_cycles(input logic [2:0] s);
    unique case (s)
      3'h1: bit_cycles = 20'(P_CLK_HZ / 150);
      3'h2: bit_cycles = 20'(P_CLK_HZ / 300);
      3'h3: bit_cycles = 20'(P_CLK_HZ / 600);
      3'h4: bit_cycles = 20'(P_CLK_HZ / 1200);
      3'h5: bit_cycles = 20'(P_CLK_HZ / 2400);
      3'h6: bit_cycles = 20'(P_CLK_HZ / 4800);
      default: bit_cycles = 20'(P_CLK_HZ / 9600);
    endcase
  endfunction : bit_cycles

  // Pin synchronisers: a change counts once stages two and three agree
  logic [3:0] pin_s1_reg;
  logic [3:0] pin_s2_reg;
  logic [3:0] pin_s3_reg;
  logic [3:0] pin_reg;
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pin_s1_reg <= 4'h0;
      pin_s2_reg <= 4'h0;
      pin_s3_reg <= 4'h0;
      pin_reg <= 4'h0;
    end else if (i_ce) begin
      pin_s1_reg <= {i_par_demand, i_sel};
      pin_s2_reg <= pin_s1_reg;
      pin_s3_reg <= pin_s2_reg;
      if (pin_s2_reg == pin_s3_reg) begin
        pin_reg <= pin_s3_reg;
      end
    end
  end
  wire [2:0] sel_now = pin_reg[2:0];
  wire demand = pin_reg[3];

  // Register bus
  logic awready_reg, wready_reg, bvalid_reg, aw_got_reg, w_got_reg;
  logic arready_reg, rvalid_reg;
  logic [1:0] bresp_reg, rresp_reg;
  logic [31:0] rdata_reg, wdata_reg;
  logic [`TPOC_ADDR_W-1:0] awaddr_reg;
  logic wstrb0_reg;
  logic ctrl_en_reg;
  tpoc_status_t status;
  wire aw_hs = i_s_axi_awvalid && awready_reg;
  wire w_hs = i_s_axi_wvalid && wready_reg;
  wire ar_hs = i_s_axi_arvalid && arready_reg;
  wire do_wr = aw_got_reg && w_got_reg && !bvalid_reg;
  wire wr_ctrl = awaddr_reg == `TPOC_CTRL_OFF;
  wire wr_ok = wr_ctrl || (awaddr_reg == `TPOC_STATUS_OFF);
  wire rd_ctrl = i_s_axi_araddr == `TPOC_CTRL_OFF;
  wire rd_stat = i_s_axi_araddr == `TPOC_STATUS_OFF;
  wire [31:0] rd_mux = rd_ctrl ? {31'h0, ctrl_en_reg} :
                       rd_stat ? status : 32'h0;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_got_reg <= 1'b0;
      w_got_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h0;
      wstrb0_reg <= 1'b0;
      ctrl_en_reg <= 1'(`TPOC_CTRL_RESET & 32'h1);
    end else if (i_ce) begin
      if (aw_hs) begin
        awaddr_reg <= i_s_axi_awaddr;
        aw_got_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (w_hs) begin
        wdata_reg <= i_s_axi_wdata;
        wstrb0_reg <= i_s_axi_wstrb[0];
        w_got_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (do_wr) begin
        aw_got_reg <= 1'b0;
        w_got_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? 2'h0 : 2'h3;
        if (wr_ctrl && wstrb0_reg) begin
          ctrl_en_reg <= wdata_reg[`TPOC_CTRL_EN_BIT];
        end
      end
      if (bvalid_reg && i_s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= 2'h0;
    end else if (i_ce) begin
      if (ar_hs) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_mux;
        rresp_reg <= (rd_ctrl || rd_stat) ? 2'h0 : 2'h3;
      end else if (rvalid_reg && i_s_axi_rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // FIFO between formatter and printer port
  logic push_valid;
  logic [7:0] push_char;
  logic fifo_in_ready, fifo_out_valid, pop;
  logic [7:0] fifo_out_char;
  tpoc_fifo #(.W(8), .D(`TPOC_FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_ce(i_ce),
    .i_in_valid(push_valid),
    .i_in_data(push_char),
    .o_in_ready(fifo_in_ready),
    .o_out_valid(fifo_out_valid),
    .o_out_data(fifo_out_char),
    .i_out_ready(pop)
  );

  // Command interpreter and line formatter
  tpoc_fmt_state_t fst_reg;
  logic host_ready_reg, esc_reg, lf_mode_reg, pt_reg, copy_pend_reg;
  logic screen_reg, rd_valid_reg, any_reg, phase_reg;
  logic [6:0] col_reg, rd_col_reg, last_reg;
  logic [4:0] row_reg;
  logic xoff_pend_reg, xon_pend_reg, xoff_sent_reg;
  logic flow_valid_reg;
  logic [7:0] flow_char_reg;

  wire host_take = i_host_valid && host_ready_reg;
  wire idle = fst_reg == TPOC_F_IDLE;
  wire copy_go = idle && !host_take && copy_pend_reg;
  wire is_esc = i_host_char == `TPOC_CH_ESC;
  wire cmd = host_take && esc_reg && !pt_reg;
  wire cmd_screen = cmd && (i_host_char == `TPOC_CH_SCREEN);
  wire cmd_line = cmd && (i_host_char == `TPOC_CH_LINE);
  wire auto_lf = host_take && !pt_reg && !esc_reg && lf_mode_reg &&
                 (i_host_char == `TPOC_CH_LF);
  wire start_screen = cmd_screen || (copy_go && !i_shift);
  wire start_line = cmd_line || auto_lf;
  wire start = start_screen || start_line;
  wire pt_exit = host_take && pt_reg && esc_reg &&
                 (i_host_char == `TPOC_CH_PT_OFF);
  wire pt_fwd = host_take && pt_reg;
  wire trim = !any_reg || (last_reg <= TRIM_LAST);
  wire [6:0] end_col = trim ? last_reg : LAST_COL;
  wire send_push = (fst_reg == TPOC_F_SEND) && phase_reg;
  wire cr_push = fst_reg == TPOC_F_CR;
  wire lf_push = fst_reg == TPOC_F_LF;

  assign push_valid = pt_fwd || send_push || cr_push || lf_push;
  always_comb begin
    push_char = i_host_char;
    if (pt_exit) begin
      push_char = `TPOC_CH_CAN;
    end else if (send_push) begin
      push_char = blank(i_scr_char) ? `TPOC_CH_SPACE : i_scr_char;
    end else if (cr_push) begin
      push_char = `TPOC_CH_CR;
    end else if (lf_push) begin
      push_char = `TPOC_CH_LF;
    end
  end

  // One host character per two cycles keeps a free FIFO slot in hand
  wire ready_next = idle && !start && !copy_go && !host_take &&
                    fifo_in_ready;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      host_ready_reg <= 1'b0;
      esc_reg <= 1'b0;
      lf_mode_reg <= 1'b0;
      pt_reg <= 1'b0;
      copy_pend_reg <= 1'b0;
    end else if (i_ce) begin
      host_ready_reg <= ready_next;
      // Set beats clear when a press meets its own service cycle
      copy_pend_reg <= i_copy_key || (copy_pend_reg && !copy_go);
      if (copy_go && i_shift) begin
        lf_mode_reg <= !lf_mode_reg;
      end
      if (host_take) begin
        esc_reg <= is_esc && !esc_reg;
        if (cmd && (i_host_char == `TPOC_CH_LF_ON)) begin
          lf_mode_reg <= 1'b1;
        end
        if (cmd && (i_host_char == `TPOC_CH_LF_OFF)) begin
          lf_mode_reg <= 1'b0;
        end
        if (cmd && (i_host_char == `TPOC_CH_PT_ON)) begin
          pt_reg <= 1'b1;
        end
        if (pt_exit) begin
          pt_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      fst_reg <= TPOC_F_IDLE;
      screen_reg <= 1'b0;
      row_reg <= 5'h0;
      col_reg <= 7'h0;
      rd_col_reg <= 7'h0;
      rd_valid_reg <= 1'b0;
      last_reg <= 7'h0;
      any_reg <= 1'b0;
      phase_reg <= 1'b0;
    end else if (i_ce) begin
      rd_valid_reg <= fst_reg == TPOC_F_SCAN;
      rd_col_reg <= col_reg;
      unique case (fst_reg)
        TPOC_F_IDLE: begin
          if (start) begin
            screen_reg <= start_screen;
            row_reg <= start_screen ? 5'h0 : i_cursor_row;
            col_reg <= 7'h0;
            any_reg <= 1'b0;
            fst_reg <= TPOC_F_SCAN;
          end
        end
        TPOC_F_SCAN: begin
          if (col_reg != LAST_COL) begin
            col_reg <= col_reg + 7'h1;
          end
          if (rd_valid_reg && !blank(i_scr_char)) begin
            last_reg <= rd_col_reg;
            any_reg <= 1'b1;
          end
          if (rd_valid_reg && (rd_col_reg == LAST_COL)) begin
            col_reg <= 7'h0;
            phase_reg <= 1'b0;
            fst_reg <= TPOC_F_SEND;
          end
        end
        TPOC_F_SEND: begin
          if (!any_reg) begin
            fst_reg <= TPOC_F_CR;
          end else if (!phase_reg) begin
            phase_reg <= 1'b1;
          end else if (fifo_in_ready) begin
            phase_reg <= 1'b0;
            col_reg <= col_reg + 7'h1;
            if (col_reg == end_col) begin
              fst_reg <= TPOC_F_CR;
            end
          end
        end
        TPOC_F_CR: begin
          if (fifo_in_ready) begin
            fst_reg <= TPOC_F_LF;
          end
        end
        TPOC_F_LF: begin
          if (fifo_in_ready) begin
            col_reg <= 7'h0;
            if (screen_reg && (row_reg != LAST_ROW)) begin
              row_reg <= row_reg + 5'h1;
              any_reg <= 1'b0;
              fst_reg <= TPOC_F_SCAN;
            end else begin
              fst_reg <= TPOC_F_DONE;
            end
          end
        end
        TPOC_F_DONE: begin
          fst_reg <= TPOC_F_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      xoff_pend_reg <= 1'b0;
      xon_pend_reg <= 1'b0;
      xoff_sent_reg <= 1'b0;
      flow_valid_reg <= 1'b0;
      flow_char_reg <= 8'h00;
    end else if (i_ce) begin
      if (start) begin
        xoff_pend_reg <= 1'b1;
        xon_pend_reg <= 1'b0;
      end else if (fst_reg == TPOC_F_DONE) begin
        xon_pend_reg <= 1'b1;
      end
      if (flow_valid_reg) begin
        if (i_flow_ready) begin
          flow_valid_reg <= 1'b0;
        end
      end else if (xoff_pend_reg && !start) begin
        xoff_pend_reg <= 1'b0;
        if (!xoff_sent_reg) begin
          flow_valid_reg <= 1'b1;
          flow_char_reg <= `TPOC_CH_XOFF;
          xoff_sent_reg <= 1'b1;
        end
      end else if (xon_pend_reg && idle && i_silo_empty && !start) begin
        xon_pend_reg <= 1'b0;
        if (xoff_sent_reg) begin
          flow_valid_reg <= 1'b1;
          flow_char_reg <= `TPOC_CH_XON;
          xoff_sent_reg <= 1'b0;
        end
      end
    end
  end

  // Printer port
  tpoc_out_state_t ost_reg;
  logic [7:0] par_data_reg;
  logic par_strobe_reg, txd_reg, hold_reg;
  logic [8:0] sh_reg;
  logic [3:0] nbits_reg;
  logic [19:0] cnt_reg, div_reg;
  wire parallel = sel_now == `TPOC_SEL_PARALLEL;
  assign pop = (ost_reg == TPOC_O_IDLE) && fifo_out_valid && ctrl_en_reg &&
               (!parallel || demand);
  wire cnt_zero = cnt_reg == 20'h0;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ost_reg <= TPOC_O_IDLE;
      par_data_reg <= 8'h00;
      par_strobe_reg <= 1'b0;
      txd_reg <= 1'b1;
      sh_reg <= 9'h1ff;
      nbits_reg <= 4'h0;
      cnt_reg <= 20'h0;
      div_reg <= 20'h0;
    end else if (i_ce) begin
      if (!cnt_zero) begin
        cnt_reg <= cnt_reg - 20'h1;
      end
      unique case (ost_reg)
        TPOC_O_IDLE: begin
          if (pop && parallel) begin
            par_data_reg <= fifo_out_char;
            ost_reg <= TPOC_O_PSET;
          end else if (pop) begin
            div_reg <= bit_cycles(sel_now) - 20'h1;
            cnt_reg <= bit_cycles(sel_now) - 20'h1;
            txd_reg <= 1'b0;
            sh_reg <= {1'b1, fifo_out_char};
            nbits_reg <= 4'h9;
            ost_reg <= TPOC_O_SER;
          end
        end
        TPOC_O_PSET: begin
          par_strobe_reg <= 1'b1;
          cnt_reg <= STB_CYC - 20'h1;
          ost_reg <= TPOC_O_PSTB;
        end
        TPOC_O_PSTB: begin
          if (cnt_zero) begin
            par_strobe_reg <= 1'b0;
            ost_reg <= TPOC_O_PHLD;
          end
        end
        TPOC_O_PHLD: begin
          ost_reg <= TPOC_O_IDLE;
        end
        TPOC_O_SER: begin
          if (cnt_zero) begin
            if (nbits_reg == 4'h0) begin
              ost_reg <= TPOC_O_IDLE;
            end else begin
              txd_reg <= sh_reg[0];
              sh_reg <= {1'b1, sh_reg[8:1]};
              nbits_reg <= nbits_reg - 4'h1;
              cnt_reg <= div_reg;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      hold_reg <= 1'b0;
    end else if (i_ce) begin
      hold_reg <= !idle || start || xoff_sent_reg;
    end
  end

  assign status = '{zero: 24'h0, demand: demand, sel: sel_now,
                    xoff_sent: xoff_sent_reg, busy: !idle,
                    passthru: pt_reg, lf_mode: lf_mode_reg};

  assign o_s_axi_awready = awready_reg;
  assign o_s_axi_wready = wready_reg;
  assign o_s_axi_bvalid = bvalid_reg;
  assign o_s_axi_bresp = bresp_reg;
  assign o_s_axi_arready = arready_reg;
  assign o_s_axi_rvalid = rvalid_reg;
  assign o_s_axi_rdata = rdata_reg;
  assign o_s_axi_rresp = rresp_reg;
  assign o_host_ready = host_ready_reg;
  assign o_scr_row = row_reg;
  assign o_scr_col = col_reg;
  assign o_flow_valid = flow_valid_reg;
  assign o_flow_char = flow_char_reg;
  assign o_par_data = par_data_reg;
  assign o_par_strobe = par_strobe_reg;
  assign o_ser_txd = txd_reg;
  assign o_hold = hold_reg;
endmodule : tpoc_top
